// [core/csw_params.svh]
`ifndef CSW_PARAMS_SVH
`define CSW_PARAMS_SVH

// ------------------------------------------------
// select count and bus widths
// ------------------------------------------------
`define CSW_NUM_SEL 12
`define CSW_ADDR_W 24
`define CSW_BOOT_IDX 0

// ------------------------------------------------
// cycle timing in clocks
// ------------------------------------------------
`define CSW_BASE_CLKS 3
`define CSW_WAIT_MAX 4'hD
`define CSW_WAIT_FAST 4'hE
`define CSW_WAIT_EXT 4'hF
`define CSW_BOOT_WAIT_RST 4'hD
`define CSW_AS_PHASE 4'h1
`define CSW_DS_EXTRA 4'h2
`define CSW_PHASE_MAX 4'hF

// ------------------------------------------------
// strap and transfer size codes
// ------------------------------------------------
`define CSW_STRAP_RST 1'b1
`define CSW_SIZE_BYTE 2'h1

`endif

// [core/csw_pkg.sv]
package csw_pkg;
    typedef enum logic [2:0] {
        CSW_IDLE = 3'h1,
        CSW_RUN = 3'h2,
        CSW_EXT = 3'h4
    } csw_state_t;
    typedef logic [3:0] csw_wait_t;
endpackage

// [core/csw_wait_counter.sv]
`timescale 1ns/1ns
`include "csw_params.svh"

module csw_wait_counter #(
    parameter int CW = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [CW-1:0] load_val,
    input wire logic abort,
    output logic expired
);

    logic [CW-1:0] count_r;
    logic busy_r;

    if (CW < 4) begin : g_bad_width
        $error("csw_wait_counter: CW too small for thirteen wait states");
    end

    // ------------------------------------------------
    // down counter, reloaded at every selected cycle that does not wait for an external acknowledge
    // ------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= load_val; // R20
        end else if (busy_r && count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy_r <= 1'b0;
        end else if (load) begin
            busy_r <= 1'b1;
        end else if (expired || abort) begin
            busy_r <= 1'b0;
        end
    end

    assign expired = busy_r && count_r == '0; // R20

    a_reload_value: assert property (@(posedge clk) disable iff (!nrst) // R20
        load |=> busy_r && count_r == $past(load_val))
        else $error("wait count not reloaded");

    a_expire_once: assert property (@(posedge clk) disable iff (!nrst) // R20
        expired && !load |=> !expired)
        else $error("wait expiry lasted more than one cycle");

endmodule

// [core/csw_boot_strap.sv]
`timescale 1ns/1ns
`include "csw_params.svh"

module csw_boot_strap (
    input wire logic clk,
    input wire logic nrst,
    input wire logic strap_in,
    output logic port16
);

    logic rst_seen_r;
    logic port16_r;

    // ------------------------------------------------
    // width strap, caught at the first edge after release
    // ------------------------------------------------
    // the reset branch takes the pull-up default; the pin itself is only
    // sampled once reset is gone, so no port feeds a reset value
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rst_seen_r <= 1'b0;
        end else begin
            rst_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            port16_r <= `CSW_STRAP_RST; // R12
        end else if (!rst_seen_r) begin
            port16_r <= strap_in; // R11
        end
    end

    assign port16 = port16_r;

    a_strap_latch: assert property (@(posedge clk) disable iff (!nrst) // R11
        !rst_seen_r |=> port16_r == $past(strap_in))
        else $error("boot width not taken from strap at release");

    a_strap_hold: assert property (@(posedge clk) disable iff (!nrst) // R11
        rst_seen_r |=> $stable(port16_r))
        else $error("boot width changed after release");

endmodule

// [core/csw_select_unit.sv]
`timescale 1ns/1ns
`include "csw_params.svh"

// Function
// R1 - twelve independent select outputs, each picking one external device
// R2 - each select can give size acknowledge, interrupt strobe or autovector
// R3 - each select waits for external acknowledges or makes its own
// R4 - internal acknowledge still made when the pin is discrete or alternate
// R5 - wait states are added only after the third clock of a cycle
// R6 - internally ended cycle lasts three clocks plus programmed waits
// R7 - wait count ranges from zero to thirteen
// R8 - fast code ends the cycle one clock before zero waits
// R9 - data-strobe timed write select asserts two clocks later
// R10 - boot select is enabled straight out of reset
// R11 - boot width taken from data line zero at reset release
// R12 - data line zero pulled up weakly, so boot width defaults to 16
// R13 - boot select has no byte lanes; byte writes to it are unsupported
// R14 - outside logic forms byte selects from transfer size and boot select
// R15 - each other select has an 8 or 16 bit port size
// R16 - 8-bit ports move data on the upper eight lines only
// R17 - writes to 8-bit ports echo the byte on the lower lines
// R18 - 16-bit memory uses address line one, 8-bit memory line zero
// R19 - byte-writable word memory uses two 16-bit selects, one per lane
// R20 - wait counter reloads each selected cycle and acknowledges on expiry; the code skips the reload when the wait code selects an external acknowledge
module csw_select_unit #(
    parameter int NSEL = `CSW_NUM_SEL,
    parameter int AW = `CSW_ADDR_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cyc_start,
    input wire logic [AW-1:0] addr,
    input wire logic rw,
    input wire logic cpu_space,
    input wire logic [1:0] transfer_size,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] data_in,
    input wire logic ext_size_acknowledge_high_n,
    input wire logic ext_size_acknowledge_low_n,
    input wire logic ext_autovector_acknowledge_n,
    input wire logic [NSEL-1:0] cfg_enable,
    input wire logic cfg_boot_load,
    input wire logic [NSEL*AW-1:0] cfg_base,
    input wire logic [NSEL*AW-1:0] cfg_mask,
    input wire logic [NSEL*4-1:0] cfg_wait_count,
    input wire logic [NSEL-1:0] cfg_port16,
    input wire logic [NSEL-1:0] cfg_autovector,
    input wire logic [NSEL-1:0] cfg_irq_strobe,
    input wire logic [NSEL-1:0] cfg_ds_timed,
    input wire logic [NSEL-1:0] cfg_pin_select,
    input wire logic [NSEL-1:0] cfg_discrete,
    output logic [NSEL-1:0] select_n,
    output logic size_acknowledge_high,
    output logic size_acknowledge_low,
    output logic autovector_acknowledge,
    output logic cycle_end,
    output logic port16,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic [15:0] rd_data,
    output logic boot_select_on,
    output logic boot_port16,
    output logic boot_byte_write,
    output logic strap_pullup_en
);

    localparam int IW = (NSEL > 1) ? $clog2(NSEL) : 1;

    if (NSEL < 1 || NSEL > 16 || AW < 2) begin : g_bad_cfg
        $error("csw_select_unit: NSEL must be 1..16 and AW at least 2");
    end

    // ------------------------------------------------
    // decode helpers
    // ------------------------------------------------
    function automatic logic addr_hit(input logic [AW-1:0] a,
                                      input logic [AW-1:0] base,
                                      input logic [AW-1:0] mask);
        addr_hit = ((a ^ base) & mask) == '0;
    endfunction

    // codes above the maximum other than fast, the external code included, fall back to the maximum
    function automatic logic [3:0] load_of(input csw_pkg::csw_wait_t w);
        if (w == `CSW_WAIT_FAST) begin
            load_of = 4'h0; // R8
        end else if (w > `CSW_WAIT_MAX) begin
            load_of = `CSW_WAIT_MAX + 4'h1; // R7
        end else begin
            load_of = w + 4'h1; // R5
        end
    endfunction

    csw_pkg::csw_state_t state_r;
    csw_pkg::csw_wait_t boot_wait_r;
    csw_pkg::csw_wait_t hit_wait;
    csw_pkg::csw_wait_t cur_wait_r;
    logic boot_on_r;
    logic strap_port16;
    logic [NSEL-1:0] en_vec;
    logic [NSEL-1:0] hit_vec;
    logic [NSEL-1:0] sel_pin_nxt;
    logic [NSEL-1:0] select_n_r;
    logic hit_any;
    logic [IW-1:0] hit_idx;
    logic hit_port16;
    logic start;
    logic expired;
    logic ext_ack;
    logic int_ack;
    logic [IW-1:0] cur_idx_r;
    logic [IW-1:0] idx_nxt;
    logic cur_port16_r;
    logic cur_autovector_acknowledge_r;
    logic cur_read_r;
    logic cur_ds_wr_r;
    logic [3:0] phase_r;
    logic sel_on_r;
    logic sel_on_nxt;
    logic [15:0] data_out_r;
    logic data_oe_r;
    logic [15:0] rd_data_r;
    logic boot_byte_r;

    // ------------------------------------------------
    // boot select enable and strap
    // ------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            boot_on_r <= 1'b1; // R10
            boot_wait_r <= `CSW_BOOT_WAIT_RST;
        end else if (cfg_boot_load) begin
            boot_on_r <= cfg_enable[`CSW_BOOT_IDX];
            boot_wait_r <= cfg_wait_count[3:0];
        end
    end

    csw_boot_strap u_strap (
        .clk(clk),
        .nrst(nrst),
        .strap_in(data_in[0]),
        .port16(strap_port16)
    );

    // weak pull-up on data line zero stays on; the board may overdrive it
    assign strap_pullup_en = 1'b1; // R12

    // ------------------------------------------------
    // address decode, lowest index wins
    // ------------------------------------------------
    for (genvar i = 0; i < NSEL; i++) begin : g_dec
        if (i == `CSW_BOOT_IDX) begin : g_boot
            assign en_vec[i] = boot_on_r; // R10
        end else begin : g_norm
            assign en_vec[i] = cfg_enable[i];
        end
        // an interrupt-strobe select answers only cpu-space cycles, others never
        assign hit_vec[i] = en_vec[i]
            && addr_hit(addr, cfg_base[i*AW +: AW], cfg_mask[i*AW +: AW])
            && (cfg_irq_strobe[i] == cpu_space); // R1 R2
    end

    always_comb begin
        hit_any = 1'b0;
        hit_idx = '0;
        for (int k = NSEL - 1; k >= 0; k--) begin
            if (hit_vec[k]) begin
                hit_any = 1'b1;
                hit_idx = k[IW-1:0];
            end
        end
    end

    always_comb begin
        if (hit_idx == `CSW_BOOT_IDX) begin
            hit_wait = boot_wait_r;
            hit_port16 = strap_port16; // R11
        end else begin
            hit_wait = cfg_wait_count[hit_idx*4 +: 4];
            hit_port16 = cfg_port16[hit_idx]; // R15
        end
    end

    assign start = cyc_start && state_r == csw_pkg::CSW_IDLE && hit_any;

    // ------------------------------------------------
    // cycle state
    // ------------------------------------------------
    csw_wait_counter #(
        .CW(4)
    ) u_wait (
        .clk(clk),
        .nrst(nrst),
        .load(start && hit_wait != `CSW_WAIT_EXT), // R20
        .load_val(load_of(hit_wait)),
        .abort(1'b0),
        .expired(expired)
    );

    assign ext_ack = !ext_size_acknowledge_high_n || !ext_size_acknowledge_low_n
        || !ext_autovector_acknowledge_n;
    assign int_ack = state_r == csw_pkg::CSW_RUN && expired; // R6
    assign cycle_end = int_ack || (state_r == csw_pkg::CSW_EXT && ext_ack); // R3

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= csw_pkg::CSW_IDLE;
        end else begin
            unique case (state_r)
                csw_pkg::CSW_IDLE: begin
                    if (start && hit_wait == `CSW_WAIT_EXT) begin
                        state_r <= csw_pkg::CSW_EXT; // R3
                    end else if (start) begin
                        state_r <= csw_pkg::CSW_RUN;
                    end
                end
                csw_pkg::CSW_RUN: begin
                    if (expired) begin
                        state_r <= csw_pkg::CSW_IDLE;
                    end
                end
                csw_pkg::CSW_EXT: begin
                    if (ext_ack) begin
                        state_r <= csw_pkg::CSW_IDLE;
                    end
                end
                default: begin
                    state_r <= csw_pkg::CSW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cur_idx_r <= '0;
            cur_wait_r <= '0;
            cur_port16_r <= 1'b0;
            cur_autovector_acknowledge_r <= 1'b0;
            cur_read_r <= 1'b0;
            cur_ds_wr_r <= 1'b0;
        end else if (start) begin
            cur_idx_r <= hit_idx;
            cur_wait_r <= hit_wait;
            cur_port16_r <= hit_port16;
            cur_autovector_acknowledge_r <= cfg_autovector[hit_idx];
            cur_read_r <= rw;
            cur_ds_wr_r <= cfg_ds_timed[hit_idx] && !rw;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_r <= '0;
        end else if (start) begin
            phase_r <= `CSW_AS_PHASE;
        end else if (state_r != csw_pkg::CSW_IDLE && phase_r != `CSW_PHASE_MAX) begin
            phase_r <= phase_r + 4'h1;
        end
    end

    // ------------------------------------------------
    // internal acknowledges
    // ------------------------------------------------
    // the pin mode is never consulted here, so a discrete or alternate pin
    // still ends its cycles
    assign size_acknowledge_high = int_ack && !cur_autovector_acknowledge_r && cur_port16_r; // R4 R15
    assign size_acknowledge_low = int_ack && !cur_autovector_acknowledge_r && !cur_port16_r; // R4 R15
    assign autovector_acknowledge = int_ack && cur_autovector_acknowledge_r; // R2
    assign port16 = cur_port16_r;

    // ------------------------------------------------
    // select pins
    // ------------------------------------------------
    // a data-strobe timed fast write ends before its select would assert;
    // users of fast termination should keep address-strobe timing
    always_comb begin
        if (start) begin
            sel_on_nxt = !(cfg_ds_timed[hit_idx] && !rw);
        end else if (cycle_end || state_r == csw_pkg::CSW_IDLE) begin
            sel_on_nxt = 1'b0;
        end else if (cur_ds_wr_r && phase_r >= `CSW_AS_PHASE + `CSW_DS_EXTRA - 4'h1) begin
            sel_on_nxt = 1'b1; // R9
        end else begin
            sel_on_nxt = sel_on_r;
        end
    end

    assign idx_nxt = start ? hit_idx : cur_idx_r;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sel_on_r <= 1'b0;
        end else begin
            sel_on_r <= sel_on_nxt;
        end
    end

    for (genvar i = 0; i < NSEL; i++) begin : g_pin
        assign sel_pin_nxt[i] = cfg_pin_select[i]
            ? !(sel_on_nxt && idx_nxt == IW'(i))
            : cfg_discrete[i]; // R1 R4
        always_ff @(posedge clk) begin
            if (!nrst) begin
                select_n_r[i] <= 1'b1;
            end else begin
                select_n_r[i] <= sel_pin_nxt[i];
            end
        end
    end

    assign select_n = select_n_r;
    assign boot_select_on = boot_on_r;
    assign boot_port16 = strap_port16;

    // ------------------------------------------------
    // data lanes
    // ------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_out_r <= '0;
        end else if (start && !rw) begin
            data_out_r <= hit_port16 ? wr_data : {wr_data[15:8], wr_data[15:8]}; // R16 R17
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_oe_r <= 1'b0;
        end else if (start) begin
            data_oe_r <= !rw;
        end else if (cycle_end) begin
            data_oe_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_data_r <= '0;
        end else if (cycle_end && cur_read_r) begin
            rd_data_r <= cur_port16_r ? data_in : {8'h00, data_in[15:8]}; // R16
        end
    end

    // the boot select carries no lane enables; a byte write to a 16-bit boot
    // port still selects the whole word, so it is flagged for software
    always_ff @(posedge clk) begin
        if (!nrst) begin
            boot_byte_r <= 1'b0;
        end else begin
            boot_byte_r <= start && hit_idx == `CSW_BOOT_IDX && !rw
                && transfer_size == `CSW_SIZE_BYTE && hit_port16; // R13
        end
    end

    assign data_out = data_out_r;
    assign data_oe = data_oe_r;
    assign rd_data = rd_data_r;
    assign boot_byte_write = boot_byte_r;

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [4:0] len_r;
    logic [4:0] exp_len;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            len_r <= '0;
        end else if (start) begin
            len_r <= 5'h1;
        end else if (state_r != csw_pkg::CSW_IDLE && len_r != 5'h1F) begin
            len_r <= len_r + 5'h1;
        end
    end

    // the start cycle is not counted, so the acknowledge lands in cycle two plus the waits
    assign exp_len = (cur_wait_r == `CSW_WAIT_FAST) ? 5'h1
        : {1'b0, cur_wait_r} + 5'(`CSW_BASE_CLKS) - 5'h1;

    sequence s_ds_write_start;
        start && cfg_ds_timed[hit_idx] && !rw;
    endsequence

    sequence s_ds_hold;
        !sel_on_r [*2];
    endsequence

    a_cycle_length: assert property ( // R6
        int_ack |-> len_r == exp_len)
        else $error("internal cycle length wrong");

    a_wait_after_three: assert property ( // R5
        int_ack && cur_wait_r != `CSW_WAIT_FAST |-> len_r >= 5'h2)
        else $error("wait cycle ended before third clock");

    a_fast_term: assert property ( // R8
        start && hit_wait == `CSW_WAIT_FAST |=> int_ack)
        else $error("fast termination not one clock early");

    a_zero_wait: assert property ( // R6
        start && hit_wait == 4'h0 |=> !int_ack ##1 int_ack)
        else $error("zero wait cycle not three clocks");

    a_max_wait: assert property ( // R7
        start && hit_wait == `CSW_WAIT_MAX |=> !int_ack [*8] ##0 !int_ack [*7] ##1 int_ack)
        else $error("thirteen wait cycle length wrong");

    a_ds_delay: assert property ( // R9
        s_ds_write_start |=> s_ds_hold)
        else $error("data strobe write select asserted early");

    a_as_assert: assert property ( // R1
        start && !(cfg_ds_timed[hit_idx] && !rw) |=> sel_on_r)
        else $error("select not asserted after start");

    a_ext_no_int: assert property ( // R3
        state_r == csw_pkg::CSW_EXT |-> !size_acknowledge_high && !size_acknowledge_low
            && !autovector_acknowledge)
        else $error("internal acknowledge during external wait");

    a_boot_reset: assert property ( // R10
        !$past(nrst) |-> boot_on_r)
        else $error("boot select not enabled from reset");

    a_lane_echo: assert property ( // R17
        data_oe_r && !cur_port16_r |-> data_out_r[7:0] == data_out_r[15:8])
        else $error("8-bit write not echoed on low lanes");

    a_rd_upper: assert property ( // R16
        cycle_end && cur_read_r && !cur_port16_r |=> rd_data_r == {8'h00, $past(data_in[15:8])})
        else $error("8-bit read not taken from upper lanes");

    a_autovector_acknowledge_kind: assert property ( // R2
        autovector_acknowledge |-> cur_autovector_acknowledge_r && !size_acknowledge_high && !size_acknowledge_low)
        else $error("autovector and size acknowledge mixed");

    a_pullup_on: assert property ( // R12
        strap_pullup_en)
        else $error("strap pull-up released");

    a_boot_byte: assert property ( // R13
        start && hit_idx == `CSW_BOOT_IDX && !rw && transfer_size == `CSW_SIZE_BYTE
            && hit_port16 |=> boot_byte_write)
        else $error("boot byte write not flagged");

endmodule

// [dv/csw_mem_model.sv]
`timescale 1ns/1ns
// ----------
// memory or peripheral on the far side of the selects
// ----------
module csw_mem_model #(
    parameter int ACK_DLY = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic strap,
    input wire logic [11:0] select_n,
    input wire logic [15:0] rd_word,
    output logic [15:0] data_in,
    output logic ack_n
);
    logic [15:0] last_r;
    logic [3:0] cnt_r;
    logic sel;
    logic rel_r;
    assign sel = select_n != 12'hfff;
    // the board holds the strap through the first edge after release, where the width is sampled;
    // a released bus shows the inverse of the last value, except pulled-up line zero
    assign data_in = (!nrst || !rel_r) ? {~last_r[15:1], strap}
        : (sel ? rd_word : {~last_r[15:1], 1'b1});
    // acknowledge line is pulled up while idle
    assign ack_n = !(sel && cnt_r >= 4'(ACK_DLY));
    always_ff @(posedge clk) begin
        last_r <= nrst ? data_in : 16'h0000;
    end
    always_ff @(posedge clk) begin
        cnt_r <= sel ? cnt_r + 4'h1 : 4'h0;
    end
    always_ff @(posedge clk) begin
        rel_r <= nrst;
    end
endmodule

// [dv/csw_select_unit_tb.sv]
`timescale 1ns/1ns
`include "csw_params.svh"
module csw_select_unit_tb;
    typedef struct {
        int idx; bit rw; logic [3:0] wt; bit p16; bit ds; bit cpu; bit bw; int endc;
    } csw_row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic strap = 1'b0;
    logic cyc_start = 1'b0;
    logic [23:0] addr = 24'h00_0000;
    logic rw = 1'b1;
    logic cpu_space = 1'b0;
    logic [1:0] transfer_size = 2'h2;
    logic [15:0] wr_data = 16'h0000;
    logic [15:0] rd_word = 16'h0000;
    logic [15:0] data_in;
    logic ack_n;
    logic [11:0] cfg_enable = 12'hfff;
    logic cfg_boot_load = 1'b0;
    logic [287:0] cfg_base;
    logic [287:0] cfg_mask;
    logic [47:0] cfg_wait_count = 48'h0000_0000_0000;
    logic [11:0] cfg_port16 = 12'h000;
    logic [11:0] cfg_autovector = 12'h080;
    logic [11:0] cfg_irq_strobe = 12'h080;
    logic [11:0] cfg_ds_timed = 12'h000;
    logic [11:0] cfg_pin_select = 12'h7ff;
    logic [11:0] cfg_discrete = 12'h800;
    logic [11:0] select_n;
    logic size_acknowledge_high, size_acknowledge_low, autovector_acknowledge, cycle_end;
    logic [15:0] data_out, rd_data;
    logic data_oe, boot_select_on, boot_port16, boot_byte_write, strap_pullup_en;
    bit boot_w = 1'b0;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    csw_row_t rows [10] = '{
        '{0, 1, 4'h0, 0, 0, 0, 0, 15},
        '{1, 1, 4'h0, 1, 0, 0, 0, 2},
        '{2, 1, 4'hD, 0, 0, 0, 0, 15},
        '{3, 0, 4'hE, 1, 0, 0, 0, 1},
        '{4, 0, 4'h2, 1, 1, 0, 0, 4},
        '{5, 0, 4'h1, 0, 0, 0, 0, 3},
        '{6, 1, 4'hF, 1, 0, 0, 0, 4},
        '{7, 1, 4'h0, 1, 0, 1, 0, 2},
        '{8, 0, 4'h0, 1, 1, 0, 0, 2},
        '{11, 0, 4'h0, 1, 0, 0, 0, 2}
    };

    csw_select_unit uut (.clk, .nrst, .cyc_start, .addr, .rw, .cpu_space, .transfer_size, .wr_data, .data_in,
        .ext_size_acknowledge_high_n(ack_n), .ext_size_acknowledge_low_n(1'b1),
        .ext_autovector_acknowledge_n(1'b1), .cfg_enable, .cfg_boot_load, .cfg_base, .cfg_mask,
        .cfg_wait_count, .cfg_port16, .cfg_autovector, .cfg_irq_strobe, .cfg_ds_timed, .cfg_pin_select,
        .cfg_discrete, .select_n, .size_acknowledge_high, .size_acknowledge_low, .autovector_acknowledge,
        .cycle_end, .port16(), .data_out, .data_oe, .rd_data, .boot_select_on, .boot_port16,
        .boot_byte_write, .strap_pullup_en);
    csw_mem_model mem (.clk, .nrst, .strap, .select_n, .rd_word, .data_in, .ack_n);

    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            n_fail++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // ----------
    // one bus cycle: drive, count cycles to the end, check lanes
    // ----------
    task automatic run(input csw_row_t r);
        int k;
        int low;
        int ex;
        bit bw;
        bit p;
        logic [15:0] wr;
        k = 0;
        low = 0;
        bw = 1'b0;
        p = (r.idx == 0) ? boot_w : r.p16;
        wr = 16'h5ac3 ^ 16'(r.idx);
        wr_data = wr;
        rd_word = ~wr;
        cfg_wait_count[r.idx*4 +: 4] = r.wt;
        cfg_port16[r.idx] = r.p16;
        cfg_ds_timed[r.idx] = r.ds;
        addr = {4'(r.idx), 20'h0_0010};
        rw = r.rw;
        cpu_space = r.cpu;
        transfer_size = r.bw ? `CSW_SIZE_BYTE : 2'h2;
        cyc_start = 1'b1;
        while (cycle_end !== 1'b1 && k < 40) begin
            @(posedge clk);
            #2;
            cyc_start = 1'b0;
            k++;
            low += int'(select_n[r.idx] === 1'b0);
            bw |= (boot_byte_write === 1'b1);
        end
        chk(k == r.endc, "cycle length");
        ex = (r.ds && !r.rw) ? ((r.endc > 2) ? r.endc - 2 : 0) : r.endc;
        if (r.idx == 11) ex = 0;
        chk(low == ex, "select span");
        if (r.wt != 4'hF) chk((r.cpu ? autovector_acknowledge : (p ? size_acknowledge_high : size_acknowledge_low)) === 1'b1, "ack kind");
        if (!r.rw) chk(data_oe === 1'b1 && data_out === (p ? wr : {wr[15:8], wr[15:8]}), "write lanes");
        @(posedge clk);
        #2;
        bw |= (boot_byte_write === 1'b1);
        chk(select_n[r.idx] === 1'b1 && data_oe === 1'b0, "release after ack");
        if (r.rw) chk(rd_data === (p ? ~wr : {8'h00, ~wr[15:8]}), "read lanes");
        chk(bw == r.bw, "boot byte write flag");
        $display("test select %0d done", r.idx);
    endtask

    initial begin
        for (int i = 0; i < 12; i++) begin
            cfg_base[i*24 +: 24] = 24'(i) << 20;
            cfg_mask[i*24 +: 24] = 24'hf0_0000;
        end
        repeat (2) @(posedge clk);
        #2;
        nrst = 1'b1;
        @(posedge clk);
        #2;
        chk(boot_port16 === 1'b0, "strap low gives 8-bit boot");
        chk(boot_select_on === 1'b1 && strap_pullup_en === 1'b1, "boot on, pull-up on");
        foreach (rows[i]) run(rows[i]);
        // no select decodes this address, so the request must vanish
        addr = 24'hf0_0000;
        cyc_start = 1'b1;
        @(posedge clk);
        #2;
        cyc_start = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        chk(select_n === 12'hfff && cycle_end === 1'b0, "unmatched request ignored");
        $display("test no hit done");
        nrst = 1'b0;
        strap = 1'b1;
        repeat (2) @(posedge clk);
        #2;
        nrst = 1'b1;
        @(posedge clk);
        #2;
        chk(boot_port16 === 1'b1, "strap high gives 16-bit boot");
        boot_w = 1'b1;
        run('{0, 0, 4'h0, 1, 0, 0, 1, 15});
        cfg_wait_count[3:0] = 4'h0;
        cfg_boot_load = 1'b1;
        @(posedge clk);
        #2;
        cfg_boot_load = 1'b0;
        run('{0, 1, 4'h0, 1, 0, 0, 0, 2});
        test_done();
    end
endmodule
